// ===== core/ioexp_pkg.sv
// Package of constants for the 8-bit serial I/O expander
package ioexp_pkg;
    // ------------------------------------------------------------
    // Register selection and defaults
    // ------------------------------------------------------------
    localparam int IOEXP_WIDTH = 8;
    localparam logic [1:0] IOEXP_REG_INPUT = 2'h0;
    localparam logic [1:0] IOEXP_REG_OUTPUT = 2'h1;
    localparam logic [1:0] IOEXP_REG_POLARITY = 2'h2;
    localparam logic [1:0] IOEXP_REG_CONFIG = 2'h3;
    localparam logic [7:0] IOEXP_OUTPUT_RST = 8'hff;
    localparam logic [7:0] IOEXP_POLARITY_RST = 8'h00;
    localparam logic [7:0] IOEXP_CONFIG_RST = 8'hff;
    localparam logic [1:0] IOEXP_CMD_RST = 2'h0;
    // ------------------------------------------------------------
    // Slave address: fixed upper five bits, two select pins below
    // ------------------------------------------------------------
    localparam logic [4:0] IOEXP_ADDR_BASE = 5'h1c;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int IOEXP_CLK_MHZ = 25;
    localparam int IOEXP_SPIKE_NS = 50;
    localparam int IOEXP_SPIKE_CYC = (IOEXP_SPIKE_NS * IOEXP_CLK_MHZ + 999) / 1000;
    localparam int IOEXP_RESET_PULSE_NS = 4;
    localparam int IOEXP_RESET_PULSE_CYC = 1;
    // ------------------------------------------------------------
    // Serial engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IOEXP_IDLE = 3'b000,
        IOEXP_ADDR = 3'b001,
        IOEXP_ACK = 3'b011,
        IOEXP_RX = 3'b010,
        IOEXP_TX = 3'b110,
        IOEXP_MACK = 3'b111
    } ioexp_state_t;
endpackage

// ===== core/ioexp_line_if.sv
// Interface carrying the filtered serial lines and their events
`timescale 1ns/1ps
interface ioexp_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// ===== core/ioexp_filter.sv
// Synchroniser, spike filter and edge and condition detector
`timescale 1ns/1ps
module ioexp_filter import ioexp_pkg::*; #(
    parameter int SPIKE_CYC = IOEXP_SPIKE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw lines
    input wire logic scl_in,
    input wire logic sda_in,
    // Filtered lines
    ioexp_line_if.src line
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [3:0] scl_cnt;
    logic [3:0] sda_cnt;
    logic scl_q;
    logic sda_q;

    // ------------------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
        end
    end

    // ------------------------------------------------------------
    // Spike filter: a level must hold before it is accepted
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            line.scl <= 1'b1;
            scl_cnt <= 4'h0;
        end else if (scl_sync[1] == line.scl) begin
            scl_cnt <= 4'h0;
        end else if (scl_cnt >= 4'(SPIKE_CYC)) begin
            line.scl <= scl_sync[1];
            scl_cnt <= 4'h0;
        end else begin
            scl_cnt <= scl_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            line.sda <= 1'b1;
            sda_cnt <= 4'h0;
        end else if (sda_sync[1] == line.sda) begin
            sda_cnt <= 4'h0;
        end else if (sda_cnt >= 4'(SPIKE_CYC)) begin
            line.sda <= sda_sync[1];
            sda_cnt <= 4'h0;
        end else begin
            sda_cnt <= sda_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Edges and bus conditions
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= line.scl;
            sda_q <= line.sda;
        end
    end

    assign line.scl_rise = line.scl && !scl_q;
    assign line.scl_fall = !line.scl && scl_q;
    assign line.start_det = scl_q && line.scl && sda_q && !line.sda;
    assign line.stop_det = scl_q && line.scl && !sda_q && line.sda;

    spike_reject_a: assert property (@(posedge clk) disable iff (rst)
        line.scl != scl_q |-> $past(scl_sync[1]) == line.scl
            && $past(scl_sync[1], 2) == line.scl && $past(scl_sync[1], 3) == line.scl)
        else $error("short clock pulse passed the filter");
endmodule

// ===== core/ioexp_core.sv
// Serial-bus 8-bit I/O expander: slave engine, registers, port and alert
`timescale 1ns/1ps
module ioexp_core import ioexp_pkg::*; #(
    parameter int WIDTH = IOEXP_WIDTH,
    parameter int SPIKE_CYC = IOEXP_SPIKE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Address select pins
    input wire logic addr_select_lo,
    input wire logic addr_select_hi,
    // Port pins
    input wire logic [WIDTH-1:0] port_pins_in,
    output logic [WIDTH-1:0] port_pins_out,
    output logic [WIDTH-1:0] port_pins_oe_n,
    output logic [WIDTH-1:0] high_side_driver,
    output logic [WIDTH-1:0] low_side_driver,
    // Alert line
    output logic alert_out,
    output logic alert_oe_n
);
    ioexp_line_if line ();
    ioexp_state_t state;
    logic [WIDTH-1:0] pin_sync1;
    logic [WIDTH-1:0] pin_sync2;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] pol_reg;
    logic [WIDTH-1:0] cfg_reg;
    logic [WIDTH-1:0] captured;
    logic [1:0] cmd;
    logic cmd_done;
    logic read_mode;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic sda_low;
    logic ack_ok;
    logic [1:0] sel_sync1;
    logic [1:0] sel_sync2;
    logic [WIDTH-1:0] input_view;
    logic [WIDTH-1:0] read_data;
    logic addr_match;
    logic input_read_ack;
    logic [WIDTH-1:0] differ;

    ioexp_filter #(
        .SPIKE_CYC(SPIKE_CYC)
    ) u_filter (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(line)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
            sel_sync1 <= 2'h0;
            sel_sync2 <= 2'h0;
        end else begin
            pin_sync1 <= port_pins_in;
            pin_sync2 <= pin_sync1;
            sel_sync1 <= {addr_select_hi, addr_select_lo};
            sel_sync2 <= sel_sync1;
        end
    end

    // Real pin level with polarity applied, whatever the direction
    assign input_view = pin_sync2 ^ pol_reg;
    assign addr_match = shreg[7:1] == {IOEXP_ADDR_BASE, sel_sync2};

    always_comb begin
        unique case (cmd)
            IOEXP_REG_INPUT: read_data = input_view;
            IOEXP_REG_OUTPUT: read_data = out_reg;
            IOEXP_REG_POLARITY: read_data = pol_reg;
            IOEXP_REG_CONFIG: read_data = cfg_reg;
        endcase
    end

    // ------------------------------------------------------------
    // Serial slave engine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IOEXP_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            read_mode <= 1'b0;
            ack_ok <= 1'b0;
            sda_low <= 1'b0;
            cmd_done <= 1'b0;
        end else if (line.start_det) begin
            state <= IOEXP_ADDR;
            bitcnt <= 4'h0;
            sda_low <= 1'b0;
        end else if (line.stop_det) begin
            state <= IOEXP_IDLE;
            sda_low <= 1'b0;
        end else begin
            unique case (state)
                IOEXP_IDLE: begin
                    sda_low <= 1'b0;
                end
                IOEXP_ADDR, IOEXP_RX: begin
                    if (line.scl_rise) begin
                        shreg <= {shreg[6:0], line.sda};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (line.scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (state == IOEXP_ADDR) begin
                            ack_ok <= addr_match;
                            read_mode <= shreg[0];
                            sda_low <= addr_match;
                            state <= addr_match ? IOEXP_ACK : IOEXP_IDLE;
                        end else begin
                            ack_ok <= 1'b1;
                            sda_low <= 1'b1;
                            state <= IOEXP_ACK;
                        end
                    end
                end
                IOEXP_ACK: begin
                    if (line.scl_fall) begin
                        if (read_mode) begin
                            shreg <= read_data;
                            sda_low <= !read_data[7];
                            bitcnt <= 4'h1;
                            state <= IOEXP_TX;
                        end else begin
                            sda_low <= 1'b0;
                            state <= IOEXP_RX;
                        end
                        if (!read_mode && ack_ok && bitcnt == 4'h0) begin
                            cmd_done <= cmd_done;
                        end
                    end
                end
                IOEXP_TX: begin
                    if (line.scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            sda_low <= 1'b0;
                            state <= IOEXP_MACK;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_low <= !shreg[6];
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                IOEXP_MACK: begin
                    if (line.scl_rise) begin
                        ack_ok <= !line.sda;
                    end else if (line.scl_fall) begin
                        if (ack_ok) begin
                            shreg <= read_data;
                            sda_low <= !read_data[7];
                            bitcnt <= 4'h1;
                            state <= IOEXP_TX;
                        end else begin
                            sda_low <= 1'b0;
                            state <= IOEXP_IDLE;
                        end
                    end
                end
                default: state <= IOEXP_IDLE;
            endcase
            if (state == IOEXP_ADDR && line.scl_fall && bitcnt == 4'h8) begin
                cmd_done <= 1'b0;
            end else if (state == IOEXP_RX && line.scl_fall && bitcnt == 4'h8) begin
                cmd_done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Command and register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd <= IOEXP_CMD_RST;
            out_reg <= IOEXP_OUTPUT_RST;
            pol_reg <= IOEXP_POLARITY_RST;
            cfg_reg <= IOEXP_CONFIG_RST;
        end else if (state == IOEXP_RX && line.scl_fall && bitcnt == 4'h8) begin
            if (!cmd_done) begin
                cmd <= shreg[1:0];
            end else begin
                unique case (cmd)
                    IOEXP_REG_INPUT: cmd <= cmd;
                    IOEXP_REG_OUTPUT: out_reg <= shreg;
                    IOEXP_REG_POLARITY: pol_reg <= shreg;
                    IOEXP_REG_CONFIG: cfg_reg <= shreg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Alert: input capture and change detection
    // ------------------------------------------------------------
    // Capture at the master acknowledge clock rise of an input read
    assign input_read_ack = state == IOEXP_MACK && line.scl_rise && cmd == IOEXP_REG_INPUT;
    // Output pins are masked; a direction change may still flag a false alert
    assign differ = (pin_sync2 ^ captured) & cfg_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            captured <= '0;
        end else if (input_read_ack) begin
            captured <= pin_sync2;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alert_oe_n <= 1'b1;
        end else begin
            alert_oe_n <= !(|differ) || input_read_ack;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            alert_out <= 1'b0;
            port_pins_out <= IOEXP_OUTPUT_RST;
            port_pins_oe_n <= '1;
            high_side_driver <= '0;
            low_side_driver <= '0;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= !sda_low;
            alert_out <= 1'b0;
            port_pins_out <= out_reg;
            port_pins_oe_n <= cfg_reg;
            high_side_driver <= ~cfg_reg & out_reg;
            low_side_driver <= ~cfg_reg & ~out_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    input_hiz_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> ((high_side_driver | low_side_driver) & $past(cfg_reg)) == '0)
        else $error("input pin has a driver on");
    out_drive_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> port_pins_out == $past(out_reg) && port_pins_oe_n == $past(cfg_reg))
        else $error("output pin does not follow register");
    alert_set_a: assert property (@(posedge clk) disable iff (rst)
        (|differ) && !input_read_ack |=> !alert_oe_n)
        else $error("alert missing on input change");
    alert_low_a: assert property (@(posedge clk) disable iff (rst) alert_out == 1'b0)
        else $error("alert driven high");
    alert_read_a: assert property (@(posedge clk) disable iff (rst)
        input_read_ack |=> alert_oe_n ##1 (captured == $past(pin_sync2, 2)))
        else $error("input read did not clear alert");
    reset_dflt_a: assert property (@(posedge clk)
        rst |=> cfg_reg == IOEXP_CONFIG_RST && out_reg == IOEXP_OUTPUT_RST
            && pol_reg == IOEXP_POLARITY_RST && state == IOEXP_IDLE)
        else $error("reset defaults not restored");
    stop_idle_a: assert property (@(posedge clk) disable iff (rst)
        line.stop_det |=> state == IOEXP_IDLE ##1 sda_oe_n)
        else $error("stop did not idle engine");
    addr_ack_a: assert property (@(posedge clk) disable iff (rst)
        state == IOEXP_ADDR && line.scl_fall && bitcnt == 4'h8 && !addr_match
        |=> state == IOEXP_IDLE ##1 sda_oe_n)
        else $error("foreign address acknowledged");
    nack_release_a: assert property (@(posedge clk) disable iff (rst)
        state == IOEXP_MACK && !ack_ok && line.scl_fall && !line.stop_det
        && !line.start_det |=> ##1 sda_oe_n)
        else $error("data line held after nack");
    read_cover: cover property (@(posedge clk) input_read_ack);
    write_cover: cover property (@(posedge clk) $changed(cfg_reg) && !rst);
    alert_cover: cover property (@(posedge clk) $fell(alert_oe_n));
endmodule

// ===== dv/ioexp_master.sv
// Serial bus master model for the expander bench
`timescale 1ns/1ps
module ioexp_master (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic sda_line,
    output logic scl_pin,
    output logic sda_drv
);
    // ------------------------------------------------------------
    // Bus idles high; clock stands still outside frames
    // ------------------------------------------------------------
    initial begin
        scl_pin = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start_cond();
        tick(2);
        sda_drv = 1'b1;
        tick(6);
        scl_pin = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl_pin = 1'b0;
    endtask
    // Stop: data rises while clock high
    task automatic stop_cond();
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl_pin = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(8);
    endtask
    // Data changes only while clock low; sampled at the end of the high phase
    // Long low phase lets the slave's delayed data settle before the clock rises
    task automatic bit_xfer(input logic b, output logic r);
        tick(2);
        sda_drv = b;
        tick(6);
        scl_pin = 1'b1;
        tick(4);
        r = sda_line;
        scl_pin = 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], q[i]);
        end
        bit_xfer(ack_in, ack_out);
    endtask
endmodule

// ===== dv/tb_ioexp_core.sv
// Self-checking bench for the serial I/O expander
`timescale 1ns/1ps
module tb_ioexp_core;
    import ioexp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b0;
    logic [7:0] ext = 8'h00;
    logic scl_pin, sda_drv, sda_out, sda_oe_n, alert_out, alert_oe_n;
    logic [7:0] pins_out, pins_oe_n, hs, ls, pin_lvl, q;
    logic sda_line, alert_line, ak;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 88;
    int cycles = 0;
    int cfg, pol, outr, cap, k;
    always #20 clk = ~clk;
    // Pull-ups on the shared lines; driven port pins show the driver
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    assign alert_line = alert_oe_n | alert_out;
    assign pin_lvl = (pins_oe_n & ext) | (~pins_oe_n & pins_out);
    ioexp_master ioexp_master_inst (.clk(clk), .sda_line(sda_line), .scl_pin(scl_pin),
        .sda_drv(sda_drv));
    ioexp_core ioexp_core_inst (.clk(clk), .rst(rst), .scl_in(scl_pin), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_lo(sel_lo),
        .addr_select_hi(sel_hi), .port_pins_in(pin_lvl), .port_pins_out(pins_out),
        .port_pins_oe_n(pins_oe_n), .high_side_driver(hs), .low_side_driver(ls),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    // Model of the device state and expected pin level
    function automatic logic [7:0] lvl_m();
        return 8'((cfg & ext) | (~cfg & outr));
    endfunction
    task automatic chk_alert();
        ioexp_master_inst.tick(12);
        chk_bit(alert_line, ((lvl_m() ^ 8'(cap)) & 8'(cfg)) == 8'h00);
        chk_bit(alert_out, 1'b0);
        chk_bit(sda_out, 1'b0);
    endtask
    task automatic chk_port();
        chk_byte(pins_oe_n, 8'(cfg));
        chk_byte(hs, 8'(~cfg & outr));
        chk_byte(ls, 8'(~cfg & ~outr));
        chk_byte(pins_out, 8'(outr));
    endtask
    task automatic cmd_phase(input logic [1:0] r);
        ioexp_master_inst.start_cond();
        ioexp_master_inst.byte_xfer({5'h1c, 2'h0, 1'b0}, 1'b1, q, ak);
        chk_bit(ak, 1'b0);
        ioexp_master_inst.byte_xfer({6'h00, r}, 1'b1, q, ak);
        chk_bit(ak, 1'b0);
    endtask
    task automatic wr_reg(input logic [1:0] r, input logic [7:0] d);
        cmd_phase(r);
        ioexp_master_inst.byte_xfer(d, 1'b1, q, ak);
        chk_bit(ak, 1'b0);
        ioexp_master_inst.stop_cond();
    endtask
    task automatic rd_reg(input logic [1:0] r, input logic [7:0] exp);
        cmd_phase(r);
        ioexp_master_inst.start_cond();
        ioexp_master_inst.byte_xfer({5'h1c, 2'h0, 1'b1}, 1'b1, q, ak);
        chk_bit(ak, 1'b0);
        ioexp_master_inst.byte_xfer(8'hff, 1'b0, q, ak);
        chk_byte(q, exp);
        ioexp_master_inst.byte_xfer(8'hff, 1'b1, q, ak);
        chk_byte(q, exp);
        ioexp_master_inst.stop_cond();
        if (r == IOEXP_REG_INPUT) cap = lvl_m();
    endtask
    task automatic do_reset();
        cfg = 8'hff;
        pol = 8'h00;
        outr = 8'hff;
        cap = 8'h00;
        ext = 8'h00;
        rst = 1'b1;
        ioexp_master_inst.tick(3);
        rst = 1'b0;
        ioexp_master_inst.tick(6);
        chk_port();
        chk_alert();
        chk_bit(sda_oe_n, 1'b1);
        rd_reg(IOEXP_REG_OUTPUT, IOEXP_OUTPUT_RST);
        rd_reg(IOEXP_REG_POLARITY, IOEXP_POLARITY_RST);
        rd_reg(IOEXP_REG_CONFIG, IOEXP_CONFIG_RST);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        // Select pins change only between frames
        for (int s = 0; s < 4; s++) begin
            {sel_hi, sel_lo} = 2'(s);
            for (int a = 0; a < 5; a++) begin
                ioexp_master_inst.start_cond();
                ioexp_master_inst.byte_xfer({5'h1c + 5'(a / 4), 2'(a), 1'b0}, 1'b1, q, ak);
                chk_bit(ak, a != s);
                ioexp_master_inst.stop_cond();
                chk_alert();
            end
        end
        {sel_hi, sel_lo} = 2'h0;
        for (int n = 0; n < 4; n++) begin
            outr = $random(seed) & 8'hff;
            pol = $random(seed) & 8'hff;
            cfg = $random(seed) & 8'hff;
            ext = 8'($random(seed));
            wr_reg(IOEXP_REG_OUTPUT, 8'(outr));
            wr_reg(IOEXP_REG_POLARITY, 8'(pol));
            wr_reg(IOEXP_REG_INPUT, 8'h5a);
            wr_reg(IOEXP_REG_CONFIG, 8'(cfg));
            chk_port();
            rd_reg(IOEXP_REG_INPUT, lvl_m() ^ 8'(pol));
            rd_reg(IOEXP_REG_OUTPUT, 8'(outr));
            rd_reg(IOEXP_REG_POLARITY, 8'(pol));
            rd_reg(IOEXP_REG_CONFIG, 8'(cfg));
            chk_alert();
            for (int m = 0; m < 3; m++) begin
                k = $random(seed) & 7;
                ext[k] = ~ext[k];
                chk_alert();
                ext[k] = ~ext[k];
                chk_alert();
                ext[k] = ~ext[k];
                chk_alert();
                rd_reg(IOEXP_REG_INPUT, lvl_m() ^ 8'(pol));
                chk_alert();
            end
        end
        do_reset();
        test_done();
    end
endmodule
